// file: src/cg_clock_gen.sv
// Clock source selection and derived clock generation with an AXI4-Lite register slave.
//
// How it works
// [RULE1] Main clock: internal when source bit 0, external, or external halved.
// [RULE2] Sources are an internal 1 MHz oscillator and an external 32768 Hz one.
// [RULE3] Secondary clock equals main clock, or main clock divided by four.
// [RULE4] Sleep turns both oscillators off whatever the enable bits say.
// [RULE5] Oscillator bits 00 both, 01 internal, 10 external, 11 internal.
// [RULE6] Instruction cycle is main clock over 6.5, 12.5, 2 or 4.
// [RULE7] Software keeps cycle select zero when ADC runs above 13 bits.
// [RULE8] Software switches only to a stable oscillator and follows with one NOP.
// [RULE9] ADC sample clock is main clock over 25, or over 50 when quartered.
// [RULE10] A conversion of N bits takes two to the N sample clocks.
// [RULE11] Beeper is secondary over 250, over 375, or external over 8.
// [RULE12] Pump clock is main over 200, main over 100, or external over 32.
// [RULE13] Chopper control is 0, 1, secondary over 500 or over 1000.
// [RULE14] Timer and LCD clock is secondary over 1000 when timer select is 0.
// [RULE15] Timer and LCD clock is external over 32 when timer select is 1.
// [RULE16] Dividers are synchronous counters that restart without runt pulses on select changes.
//
// Local design decision: register access over AXI4-Lite.
`include "cg_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module cg_clock_gen #(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              ext_osc_in,
  input  wire logic              sleep_mode,
  output logic                   main_clock,
  output logic                   instr_clock,
  output logic                   adc_sample_clock,
  output logic                   adc_conversion_done,
  output logic                   beeper_clock,
  output logic                   pump_clock,
  output logic                   pump_enable,
  output logic                   chopper_ctrl,
  output logic                   timer_lcd_clock,
  output logic                   int_osc_en,
  output logic                   ext_osc_en,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  localparam logic [`CG_INT_CNT_W-1:0] INT_HALF = `CG_INT_CNT_W'(`CG_INT_OSC_CYCLES / 2);
  localparam logic [`CG_INT_CNT_W-1:0] INT_LAST = `CG_INT_CNT_W'(`CG_INT_OSC_CYCLES - 1);
  localparam logic [ADDR_W-1:0] ADDR_CLK_SRC = ADDR_W'({`CG_IDX_CLK_SRC, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_PER_CLK = ADDR_W'({`CG_IDX_PER_CLK, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_ADC_RES = ADDR_W'({`CG_IDX_ADC_RES, 2'b00});

  cg_pkg::cg_state_type st;
  cg_pkg::cg_state_type next_st;

  logic                                    src_bit;
  logic                                    quarter_bit;
  logic                                    cycle_bit;
  logic                                    halve_bit;
  logic                                    int_tick;
  logic                                    ext_edge;
  logic                                    ext_rise;
  logic                                    main_tick;
  logic                                    sec_tick;
  logic [`CG_CH_NUM-1:0]                   ch_tick;
  logic [`CG_CH_NUM-1:0][`CG_DIV_W-1:0]    ch_period;
  cg_pkg::cg_tick_src_type [`CG_CH_NUM-1:0] ch_src;
  wire logic [`CG_CH_NUM-1:0][`CG_DIV_W-1:0] div_cnt;
  wire logic [`CG_CH_NUM-1:0]              div_out;

  assign src_bit     = st.clk_src_ctl[`CG_BIT_SOURCE];
  assign quarter_bit = st.clk_src_ctl[`CG_BIT_QUARTER];
  assign cycle_bit   = st.clk_src_ctl[`CG_BIT_CYCLE];
  assign halve_bit   = st.clk_src_ctl[`CG_BIT_HALVE];

  // Oscillators and divider selection. Every clock is a tick in the sys_clk domain, one tick
  // per half period, so that the 6.5 and 12.5 ratios come out as whole tick counts.
  always_comb begin
    int_tick  = st.int_en && (st.int_cnt == INT_HALF || st.int_cnt == INT_LAST); // RULE2
    ext_edge  = st.ext_en && (st.ext_sync2 != st.ext_prev);                         // RULE2
    ext_rise  = ext_edge && st.ext_sync2;
    main_tick = src_bit ? (halve_bit ? ext_rise : ext_edge) : int_tick;          // RULE1
    sec_tick  = quarter_bit ? (main_tick && st.q_cnt == 2'h3) : main_tick;       // RULE3
    unique case ({cycle_bit, quarter_bit})                                       // RULE6
      2'b00:   ch_period[`CG_CH_INSTR] = `CG_HALF_INSTR_00;
      2'b01:   ch_period[`CG_CH_INSTR] = `CG_HALF_INSTR_01;
      2'b10:   ch_period[`CG_CH_INSTR] = `CG_HALF_INSTR_10;
      2'b11:   ch_period[`CG_CH_INSTR] = `CG_HALF_INSTR_11;
    endcase
    ch_src[`CG_CH_INSTR]   = cg_pkg::cg_src_main;
    ch_period[`CG_CH_ADC]  = quarter_bit ? `CG_HALF_ADC_1 : `CG_HALF_ADC_0;   // RULE9
    ch_src[`CG_CH_ADC]     = cg_pkg::cg_src_main;
    if (!st.per_clk_ctl[`CG_BIT_BEEP]) begin                                     // RULE11
      ch_period[`CG_CH_BEEP] = `CG_HALF_BEEP_0;
      ch_src[`CG_CH_BEEP]    = cg_pkg::cg_src_sec;
    end else if (!src_bit) begin
      ch_period[`CG_CH_BEEP] = `CG_HALF_BEEP_1;
      ch_src[`CG_CH_BEEP]    = cg_pkg::cg_src_sec;
    end else begin
      ch_period[`CG_CH_BEEP] = `CG_HALF_BEEP_EXT;
      ch_src[`CG_CH_BEEP]    = cg_pkg::cg_src_ext;
    end
    if (src_bit) begin                                                           // RULE12
      ch_period[`CG_CH_PUMP] = `CG_HALF_EXT_32;
      ch_src[`CG_CH_PUMP]    = cg_pkg::cg_src_ext;
    end else begin
      ch_period[`CG_CH_PUMP] = st.per_clk_ctl[`CG_BIT_PUMP_RATE] ? `CG_HALF_PUMP_1
                                                                  : `CG_HALF_PUMP_0;
      ch_src[`CG_CH_PUMP]    = cg_pkg::cg_src_main;
    end
    ch_period[`CG_CH_CHOP] = st.per_clk_ctl[`CG_BIT_CHOP_LO] ? `CG_HALF_CHOP_1
                                                              : `CG_HALF_CHOP_0;   // RULE13
    ch_src[`CG_CH_CHOP]    = cg_pkg::cg_src_sec;
    if (st.clk_src_ctl[`CG_BIT_TIMER]) begin                                     // RULE15
      ch_period[`CG_CH_TIMER] = `CG_HALF_EXT_32;
      ch_src[`CG_CH_TIMER]    = cg_pkg::cg_src_ext;
    end else begin                                                               // RULE14
      ch_period[`CG_CH_TIMER] = `CG_HALF_TIMER;
      ch_src[`CG_CH_TIMER]    = cg_pkg::cg_src_sec;
    end
    for (int k = 0; k < `CG_CH_NUM; k++) begin
      unique case (ch_src[k])
        cg_pkg::cg_src_main: ch_tick[k] = main_tick;
        cg_pkg::cg_src_sec:  ch_tick[k] = sec_tick;
        default:             ch_tick[k] = ext_edge;
      endcase
    end
  end

  // A restart parks the counter on its last low count, so the first high phase after a change
  // is a full one rather than a shortened sliver.
  for (genvar i = 0; i < `CG_CH_NUM; i++) begin : g_div
    logic [`CG_DIV_W-1:0] inc;
    logic [`CG_DIV_W-1:0] nc;
    logic                 no;
    always_comb begin
      inc = st.cnt[i] + `CG_DIV_W'(1);
      nc  = st.cnt[i];
      no  = st.out[i];
      if (ch_period[i] != st.prev_period[i] || ch_src[i] != st.prev_src[i]) begin // RULE16
        nc = ch_period[i] - `CG_DIV_W'(1);
        no = 1'b0;
      end else if (ch_tick[i]) begin                                             // RULE16
        nc = (inc >= ch_period[i]) ? '0 : inc;
        no = nc < ((ch_period[i] + `CG_DIV_W'(1)) >> 1);
      end
    end
    assign div_cnt[i] = nc;
    assign div_out[i] = no;
  end

  always_comb begin
    logic                 aw_fire;
    logic                 w_fire;
    logic                 have_aw;
    logic                 have_w;
    logic [ADDR_W-1:0]    waddr;
    logic [7:0]           wbyte;
    logic                 wlane;
    logic [ADDR_W-1:0]    raddr;
    aw_fire = s_axi_awvalid && st.awready;
    w_fire  = s_axi_wvalid && st.wready;
    have_aw = st.aw_got || aw_fire;
    have_w  = st.w_got || w_fire;
    waddr   = aw_fire ? s_axi_awaddr : ADDR_W'(st.aw_addr);
    wbyte   = w_fire ? s_axi_wdata[7:0] : st.w_data;
    wlane   = w_fire ? s_axi_wstrb[0] : st.w_lane0;
    raddr   = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    next_st = st;

    next_st.ext_sync1 = ext_osc_in;
    next_st.ext_sync2 = st.ext_sync1;
    next_st.ext_prev  = st.ext_sync2;
    if (sleep_mode) begin                                                        // RULE4
      next_st.int_en = 1'b0;
      next_st.ext_en = 1'b0;
    end else begin                                                               // RULE5
      next_st.int_en = st.clk_src_ctl[`CG_BIT_OSC_HI:`CG_BIT_OSC_LO] != 2'b10;
      next_st.ext_en = !st.clk_src_ctl[`CG_BIT_OSC_LO];
    end
    if (!st.int_en) begin
      next_st.int_cnt = '0;
    end else begin                                                               // RULE2
      next_st.int_cnt = (st.int_cnt == INT_LAST) ? '0 : st.int_cnt + `CG_INT_CNT_W'(1);
    end
    if (main_tick) begin                                                         // RULE1
      next_st.main_lvl = !st.main_lvl;
      next_st.q_cnt    = st.q_cnt + 2'h1;                                        // RULE3
    end
    next_st.cnt         = div_cnt;
    next_st.out         = div_out;
    next_st.prev_period = ch_period;
    next_st.prev_src    = ch_src;
    next_st.pump_clk    = div_out[`CG_CH_PUMP] && st.per_clk_ctl[`CG_BIT_PUMP_EN];
    unique case (st.per_clk_ctl[`CG_BIT_CHOP_HI:`CG_BIT_CHOP_LO])                 // RULE13
      2'b00:   next_st.chop = 1'b0;
      2'b01:   next_st.chop = 1'b1;
      default: next_st.chop = div_out[`CG_CH_CHOP];
    endcase

    next_st.conv_done = 1'b0;
    if (div_out[`CG_CH_ADC] && !st.out[`CG_CH_ADC]) begin                        // RULE10
      if ((17'(st.conv_cnt) + 17'h00001) == (17'h00001 << st.adc_res)) begin
        next_st.conv_cnt  = '0;
        next_st.conv_done = 1'b1;
      end else begin
        next_st.conv_cnt = st.conv_cnt + `CG_CONV_W'(1);
      end
    end

    // Address and data may arrive in either order; each is held until its partner shows up.
    if (aw_fire) begin
      next_st.aw_addr = s_axi_awaddr[7:0];
      next_st.aw_got  = 1'b1;
    end
    if (w_fire) begin
      next_st.w_data  = s_axi_wdata[7:0];
      next_st.w_lane0 = s_axi_wstrb[0];
      next_st.w_got   = 1'b1;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (have_aw && have_w && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = `CG_RESP_OKAY;
      if ({waddr[ADDR_W-1:2], 2'b00} == ADDR_CLK_SRC) begin
        if (wlane) begin
          next_st.clk_src_ctl = wbyte & `CG_CLK_SRC_MASK;
        end
      end else if ({waddr[ADDR_W-1:2], 2'b00} == ADDR_PER_CLK) begin
        if (wlane) begin
          next_st.per_clk_ctl = wbyte & `CG_PER_CLK_MASK;
        end
      end else if ({waddr[ADDR_W-1:2], 2'b00} == ADDR_ADC_RES) begin
        if (wlane) begin
          next_st.adc_res  = wbyte[3:0];
          next_st.conv_cnt = '0;
        end
      end else begin
        next_st.bresp = `CG_RESP_SLVERR;
      end
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready  = !next_st.w_got && !next_st.bvalid;

    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `CG_RESP_OKAY;
      if (raddr == ADDR_CLK_SRC) begin
        next_st.rdata = {24'h000000, st.clk_src_ctl};
      end else if (raddr == ADDR_PER_CLK) begin
        next_st.rdata = {24'h000000, st.per_clk_ctl};
      end else if (raddr == ADDR_ADC_RES) begin
        next_st.rdata = {21'h000000, st.main_lvl, st.ext_en, st.int_en, 4'h0, st.adc_res};
      end else begin
        next_st.rdata = 32'h00000000;
        next_st.rresp = `CG_RESP_SLVERR;
      end
    end
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st             <= '0;
      st.clk_src_ctl <= `CG_CLK_SRC_RESET;
      st.per_clk_ctl <= `CG_PER_CLK_RESET;
      st.adc_res     <= `CG_ADC_RES_RESET;
      st.awready     <= 1'b1;
      st.wready      <= 1'b1;
      st.arready     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign main_clock          = st.main_lvl;
  assign instr_clock         = st.out[`CG_CH_INSTR];
  assign adc_sample_clock    = st.out[`CG_CH_ADC];
  assign adc_conversion_done = st.conv_done;
  assign beeper_clock        = st.out[`CG_CH_BEEP];
  assign pump_clock          = st.pump_clk;
  assign pump_enable         = st.per_clk_ctl[`CG_BIT_PUMP_EN];
  assign chopper_ctrl        = st.chop;
  assign timer_lcd_clock     = st.out[`CG_CH_TIMER];
  assign int_osc_en          = st.int_en;
  assign ext_osc_en          = st.ext_en;
  assign s_axi_awready       = st.awready;
  assign s_axi_wready        = st.wready;
  assign s_axi_bvalid        = st.bvalid;
  assign s_axi_bresp         = st.bresp;
  assign s_axi_arready       = st.arready;
  assign s_axi_rvalid        = st.rvalid;
  assign s_axi_rdata         = st.rdata;
  assign s_axi_rresp         = st.rresp;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sleep_osc_a: assert property (sleep_mode |=> !int_osc_en && !ext_osc_en) // RULE4
    else $error("oscillator still enabled in sleep");
  osc_ctrl_a: assert property (!sleep_mode && st.clk_src_ctl[7:6] == 2'b11 |=> int_osc_en && !ext_osc_en) // RULE5
    else $error("oscillator control 11 not internal only");
  int_rate_a: assert property (int_tick |=> !int_tick [*8]) // RULE2
    else $error("internal oscillator ticks too close");
  main_src_a: assert property (!src_bit && st.int_en && st.int_cnt == INT_LAST |=> main_clock != $past(main_clock)) // RULE1
    else $error("main clock missed internal tick");
  quarter_a: assert property (quarter_bit && sec_tick |-> st.q_cnt == 2'h3) // RULE3
    else $error("secondary tick not on fourth main tick");
  instr_ratio_a: assert property (!cycle_bit && !quarter_bit |-> ch_period[0] == 11'h00D) // RULE6
    else $error("instruction cycle ratio wrong");
  adc_ratio_a: assert property (quarter_bit |-> ch_period[1] == 11'h064) // RULE9
    else $error("adc sample ratio wrong");
  beep_ext_a: assert property (src_bit && st.per_clk_ctl[1] |-> ch_period[2] == 11'h010 && ch_tick[2] == ext_edge) // RULE11
    else $error("beeper not external over 8");
  pump_rate_a: assert property (!src_bit && st.per_clk_ctl[0] |-> ch_period[3] == 11'h0C8) // RULE12
    else $error("pump ratio wrong");
  chop_const_a: assert property (st.per_clk_ctl[3:2] == 2'b01 |=> chopper_ctrl) // RULE13
    else $error("chopper not held high");
  timer_int_a: assert property (!st.clk_src_ctl[5] |-> ch_period[5] == 11'h7D0 && ch_tick[5] == sec_tick) // RULE14
    else $error("timer clock not secondary over 1000");
  timer_ext_a: assert property (st.clk_src_ctl[5] |-> ch_period[5] == 11'h040 && ch_tick[5] == ext_edge) // RULE15
    else $error("timer clock not external over 32");
  conv_len_a: assert property (adc_conversion_done && $stable(st.adc_res) |-> $past(st.conv_cnt) == 16'((17'h00001 << st.adc_res) - 17'h00001)) // RULE10
    else $error("conversion length wrong");

  sequence sel_change;
    ch_period[0] != st.prev_period[0];
  endsequence
  sequence parked_low;
    st.cnt[0] == $past(ch_period[0]) - 11'h001 && !instr_clock;
  endsequence
  restart_a: assert property (sel_change |=> parked_low) // RULE16
    else $error("divider did not restart cleanly");
  wrap_a: assert property (ch_period[0] == st.prev_period[0] && ch_tick[0] && st.cnt[0] == ch_period[0] - 11'h001 |=> st.cnt[0] == 11'h000 && instr_clock) // RULE16
    else $error("divider wrap wrong");

  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  axi_wresp_a: assert property (wr_both |=> s_axi_bvalid ##0 !s_axi_awready)
    else $error("write response missing");

endmodule // cg_clock_gen

`default_nettype wire

// file: src/cg_defs.svh
// Offsets, field positions, reset values and timing counts of the clock generator.
`ifndef CG_DEFS_SVH
`define CG_DEFS_SVH

`define CG_IDX_CLK_SRC      6'h14
`define CG_IDX_PER_CLK      6'h15
`define CG_IDX_ADC_RES      6'h16
`define CG_CLK_SRC_RESET    8'h00
`define CG_PER_CLK_RESET    8'h00
`define CG_ADC_RES_RESET    4'hE
`define CG_CLK_SRC_MASK     8'hEF
`define CG_PER_CLK_MASK     8'h4F
`define CG_BIT_SOURCE       0
`define CG_BIT_QUARTER      1
`define CG_BIT_CYCLE        2
`define CG_BIT_HALVE        3
`define CG_BIT_TIMER        5
`define CG_BIT_OSC_LO       6
`define CG_BIT_OSC_HI       7
`define CG_BIT_PUMP_RATE    0
`define CG_BIT_BEEP         1
`define CG_BIT_CHOP_LO      2
`define CG_BIT_CHOP_HI      3
`define CG_BIT_PUMP_EN      6
`define CG_SYS_CLK_PERIOD_NS 40
`define CG_INT_OSC_PERIOD_NS 1000
`define CG_INT_OSC_CYCLES   (`CG_INT_OSC_PERIOD_NS / `CG_SYS_CLK_PERIOD_NS)
`define CG_INT_CNT_W        5
`define CG_DIV_W            11
`define CG_CH_NUM           6
`define CG_CH_INSTR         0
`define CG_CH_ADC           1
`define CG_CH_BEEP          2
`define CG_CH_PUMP          3
`define CG_CH_CHOP          4
`define CG_CH_TIMER         5
`define CG_HALF_INSTR_00    11'h00D
`define CG_HALF_INSTR_01    11'h019
`define CG_HALF_INSTR_10    11'h004
`define CG_HALF_INSTR_11    11'h008
`define CG_HALF_ADC_0       11'h032
`define CG_HALF_ADC_1       11'h064
`define CG_HALF_BEEP_0      11'h1F4
`define CG_HALF_BEEP_1      11'h2EE
`define CG_HALF_BEEP_EXT    11'h010
`define CG_HALF_PUMP_0      11'h190
`define CG_HALF_PUMP_1      11'h0C8
`define CG_HALF_EXT_32      11'h040
`define CG_HALF_CHOP_0      11'h3E8
`define CG_HALF_CHOP_1      11'h7D0
`define CG_HALF_TIMER       11'h7D0
`define CG_CONV_W           16
`define CG_RESP_OKAY        2'h0
`define CG_RESP_SLVERR      2'h2

`endif

// file: src/cg_pkg.sv
// Types shared by the clock generator.
`include "cg_defs.svh"
package cg_pkg;
  typedef enum logic [1:0] {cg_src_main, cg_src_sec, cg_src_ext} cg_tick_src_type;

  typedef struct packed {
    logic                                    ext_sync1;
    logic                                    ext_sync2;
    logic                                    ext_prev;
    logic                                    int_en;
    logic                                    ext_en;
    logic [`CG_INT_CNT_W-1:0]                int_cnt;
    logic                                    main_lvl;
    logic [1:0]                              q_cnt;
    logic [`CG_CH_NUM-1:0][`CG_DIV_W-1:0]    cnt;
    logic [`CG_CH_NUM-1:0]                   out;
    logic [`CG_CH_NUM-1:0][`CG_DIV_W-1:0]    prev_period;
    cg_tick_src_type [`CG_CH_NUM-1:0]        prev_src;
    logic                                    pump_clk;
    logic                                    chop;
    logic [`CG_CONV_W-1:0]                   conv_cnt;
    logic                                    conv_done;
    logic [7:0]                              clk_src_ctl;
    logic [7:0]                              per_clk_ctl;
    logic [3:0]                              adc_res;
    logic                                    aw_got;
    logic [7:0]                              aw_addr;
    logic                                    w_got;
    logic [7:0]                              w_data;
    logic                                    w_lane0;
    logic                                    awready;
    logic                                    wready;
    logic                                    bvalid;
    logic [1:0]                              bresp;
    logic                                    arready;
    logic                                    rvalid;
    logic [31:0]                             rdata;
    logic [1:0]                              rresp;
  } cg_state_type;
endpackage

// file: verification/cg_ext_osc_model.sv
// External 32768 Hz crystal model that feeds the external oscillator pin.
`timescale 1ns/1ns
`default_nettype none
module cg_ext_osc_model #(
  parameter int HALF_NS = 15259
) (
  input  wire logic enable,
  output var  logic osc_out
);
  // A stopped crystal rests low rather than freezing at its last level.
  initial begin
    osc_out = 1'b0;
    forever begin
      #(HALF_NS);
      osc_out = enable ? ~osc_out : 1'b0;
    end
  end
endmodule // cg_ext_osc_model
`default_nettype wire

// file: verification/mcu_clock_generator_bench.sv
// Self-checking bench for the clock generator.
`include "cg_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module mcu_clock_generator_bench;
  localparam logic [7:0] SRC = {`CG_IDX_CLK_SRC, 2'b00};
  localparam logic [7:0] PER = {`CG_IDX_PER_CLK, 2'b00};
  localparam logic [7:0] RES = {`CG_IDX_ADC_RES, 2'b00};
  localparam logic [1:0] OK = `CG_RESP_OKAY;
  localparam logic [1:0] ERR = `CG_RESP_SLVERR;
  logic sys_clk = 1'b0, arst_n = 1'b0, sleep_mode = 1'b0, ext_osc_in;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic main, instr, adc, done, beep, pump, pump_en, chop, tmr, int_en, ext_en;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] taps;
  int n_mismatch = 0, compares = 0, k;
  assign taps = {done, tmr, chop, pump, beep, adc, instr, main};
  always #20 sys_clk = ~sys_clk;
  cg_ext_osc_model osc (.enable(ext_en), .osc_out(ext_osc_in));
  cg_clock_gen #(.ADDR_W(8)) uut (.sys_clk(sys_clk), .arst_n(arst_n), .ext_osc_in(ext_osc_in),
    .sleep_mode(sleep_mode), .main_clock(main), .instr_clock(instr), .adc_sample_clock(adc),
    .adc_conversion_done(done), .beeper_clock(beep), .pump_clock(pump), .pump_enable(pump_en),
    .chopper_ctrl(chop), .timer_lcd_clock(tmr), .int_osc_en(int_en), .ext_osc_en(ext_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task end_of_test;
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // In the tasks, design outputs are sampled at the falling edge, so the edge that launches them never races
  // the read. bready and rready stay high; each task only releases its valid lines.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       ardy;
    logic       wrdy;
    logic       vld;
    logic [1:0] rsp;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge sys_clk);
      ardy = awready;
      wrdy = wready;
      vld = bvalid;
      rsp = bresp;
      @(posedge sys_clk);
      if (ardy) awvalid <= 1'b0;
      if (wrdy) wvalid <= 1'b0;
      if (vld) begin
        chk(32'(rsp), 32'(er));
        return;
      end
    end
    n_mismatch++;
    end_of_test();
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic        rdy;
    logic        vld;
    logic [31:0] got;
    logic [1:0]  rsp;
    araddr <= a;
    arvalid <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge sys_clk);
      rdy = arready;
      vld = rvalid;
      got = rdata;
      rsp = rresp;
      @(posedge sys_clk);
      if (rdy) arvalid <= 1'b0;
      if (vld) begin
        chk(got, d);
        chk(32'(rsp), 32'(er));
        return;
      end
    end
    n_mismatch++;
    end_of_test();
  endtask
  // Counts sys_clk cycles across n periods of one tap, starting at a rising edge.
  task automatic meas(input int ch, input int n, input int exp, input int tol);
    int c = 0, r = -1;
    logic p = 1'b1;
    while (c < 60000 && r < n) begin
      @(negedge sys_clk);
      if (taps[ch] === 1'b1 && p === 1'b0) begin
        r++;
        if (r == 0) c = 0;
      end
      p = taps[ch];
      if (r < n) c++;
    end
    @(posedge sys_clk);
    if (r < n) begin
      n_mismatch++;
      end_of_test();
    end
    chk((c > exp + tol || c < exp - tol) ? c : exp, exp);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd(SRC, 32'h0, OK);
    wr(PER, 32'hFFFFFFFF, OK);
    rd(PER, 32'h4F, OK);
    wr(8'h5C, 32'hFF, ERR);
    rd(8'h5C, 32'h0, ERR);
    for (k = 0; k < 4; k++) begin
      wr(SRC, {24'h0, 2'(k), 6'h00}, OK);
      repeat (3) @(posedge sys_clk);
      chk(32'({int_en, ext_en}), 32'({k != 2, k % 2 == 0}));
    end
    wr(SRC, 32'h0, OK);
    sleep_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(32'({int_en, ext_en}), 32'h0);
    sleep_mode <= 1'b0;
    wr(RES, 32'h2, OK);
    wr(PER, 32'h4A, OK);
    fork
      meas(0, 1, 25, 0);
      meas(1, 2, 325, 0);
      meas(2, 1, 625, 0);
      meas(4, 1, 5000, 0);
      meas(6, 1, 25000, 0);
      meas(7, 1, 2500, 0);
      begin
        fork
          meas(3, 1, 9375, 0);
          meas(5, 1, 12500, 0);
        join
        wr(PER, 32'h4C, OK);
        fork
          meas(3, 1, 6250, 0);
          meas(5, 1, 25000, 0);
        join
      end
    join
    wr(SRC, 32'h02, OK);
    wr(PER, 32'h45, OK);
    repeat (3) @(posedge sys_clk);
    chk(32'(chop), 32'h1);
    fork
      meas(1, 2, 625, 0);
      meas(2, 1, 1250, 0);
      meas(4, 1, 2500, 0);
    join
    wr(PER, 32'h0, OK);
    repeat (3) @(posedge sys_clk);
    chk(32'({chop, pump, pump_en}), 32'h0);
    wr(SRC, 32'h04, OK);
    meas(1, 2, 100, 0);
    wr(SRC, 32'h06, OK);
    meas(1, 2, 200, 0);
    wr(PER, 32'h42, OK);
    wr(SRC, 32'h21, OK);
    fork
      meas(0, 2, 1526, 3);
      meas(3, 1, 6104, 3);
      meas(4, 1, 24414, 3);
      meas(6, 1, 24414, 3);
    join
    wr(SRC, 32'h09, OK);
    meas(0, 1, 1526, 3);
    end_of_test();
  end
endmodule // mcu_clock_generator_bench
`default_nettype wire
